// *** rtl/pvc_pkg.sv ***
// Notes on behaviour
// R1 - corrected value is sample times slope plus offset
// R2 - offset held within -1999 to 9999, reset zero
// R3 - slope held 0.001 to 9.999, reset 1.000
// R4 - averaging off,2,4,8,16,32; reset off
// R5 - averaging enabled separately per input channel
// R6 - average is mean of last N samples; code divides the partial sum by N until N samples have arrived
// R7 - analog span maps linearly between scaling limits
// R8 - decimal place defaults zero, adjustable
// R9 - cooling only in heating/cooling control type
// R10 - reset: out1 heat, out2 none, aux alarms
// R11 - heater fault option puts heater alarm on aux1; code puts program end there when program pattern on
// R12 - mode change reinitialises all output assignments
// R13 - four aux, no out2: cooling on aux4
// R14 - program pattern on: aux1 signals program end
// R15 - direct action swaps heating and cooling outputs
// R16 - invert event flips configured action direction
// R17 - dead band centred on set point, width parameter
// R18 - negative dead band gives heat/cool overlap
// R19 - output may step at manual/auto changeover
// R20 - dead band resets to zero
// R21 - configuring party sets band and cooling tuning
// R22 - tuning method 0..3, reset same-as-heating
`default_nettype none
package pvc_pkg;
  localparam int PV_W = 16;
  localparam int SLOPE_W = 14;
  localparam logic [13:0] SLOPE_MIN = 14'h0001;
  localparam logic [13:0] SLOPE_MAX = 14'h270f;
  localparam logic [13:0] SLOPE_UNITY = 14'h03e8;
  localparam logic signed [15:0] OFS_MIN = -16'sd1999;
  localparam logic signed [15:0] OFS_MAX = 16'sh270f;
  localparam logic signed [15:0] OFS_RESET = 16'sh0000;
  localparam logic [2:0] AVG_OFF = 3'h0;
  localparam logic [2:0] AVG_MAX_CODE = 3'h5;
  localparam logic signed [15:0] SCALE_LO_RESET = 16'sh0000;
  localparam logic signed [15:0] SCALE_HI_RESET = 16'sh0064;
  localparam logic [1:0] DEC_RESET = 2'h0;
  localparam logic signed [15:0] DB_RESET = 16'sh0000;
  localparam int HIST_DEPTH_W = 5;
  localparam int SUM_W = PV_W + HIST_DEPTH_W + 1;

  typedef enum logic [1:0] {
    TUNE_SAME = 2'h0, TUNE_LINEAR = 2'h1, TUNE_AIR = 2'h2, TUNE_WATER = 2'h3
  } pvc_tune_e;
  localparam pvc_tune_e TUNE_RESET = TUNE_SAME;

  typedef enum logic [3:0] {
    FN_NONE = 4'h0, FN_HEAT = 4'h1, FN_COOL = 4'h2, FN_ALM1 = 4'h3, FN_ALM2 = 4'h4,
    FN_ALM3 = 4'h5, FN_ALM4 = 4'h6, FN_HEATER = 4'h7, FN_PEND = 4'h8
  } pvc_func_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_CORR = 3'b010, ST_AVG = 3'b100
  } pvc_state_e;

  // configuration written by software in one strobe
  typedef struct packed {
    logic [13:0] slope;
    logic signed [15:0] offset;
    logic [2:0] avg_code;
    logic signed [15:0] scale_lo;
    logic signed [15:0] scale_hi;
    logic [1:0] decimal_place_setting;
    logic signed [15:0] dead_band;
    pvc_tune_e tune;
    logic heat_cool;
    logic direct;
    logic prog_on;
    logic analog;
  } pvc_cfg_s;

  // one conditioned process value
  typedef struct packed {
    logic ch;
    logic signed [15:0] value;
    logic [1:0] decimals;
  } pvc_pv_s;
endpackage
`default_nettype wire

// *** rtl/pvc_hist_mem.sv ***
`default_nettype none
// sample history, registered read port
module pvc_hist_mem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // write and registered read
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// *** rtl/pvc_skid_buf.sv ***
`default_nettype none
// two-entry buffer; output data straight from a register
module pvc_skid_buf #(
  parameter int W = 19
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] slot0, slot1, next_slot0, next_slot1;
  logic [1:0] count, next_count;
  logic push, pop, next_valid;

  if (W < 1) begin : g_bad_width
    $error("pvc_skid_buf: width must be positive");
  end

  assign in_ready = (count != 2'h2);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = slot0;

  // slot0 is head; slot1 holds the word behind it
  always_comb begin
    next_slot0 = slot0;
    next_slot1 = slot1;
    next_count = count;
    if (pop) begin
      next_slot0 = slot1;
    end
    if (push) begin
      if (count == 2'h0 || (count == 2'h1 && pop)) begin
        next_slot0 = in_data;
      end else begin
        next_slot1 = in_data;
      end
    end
    next_count = count + {1'b0, push} - {1'b0, pop};
    // valid kept in its own flop so the output leaves a register
    next_valid = (next_count != 2'h0);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      slot0 <= '0;
      slot1 <= '0;
      count <= 2'h0;
      out_valid <= 1'b0;
    end else begin
      slot0 <= next_slot0;
      slot1 <= next_slot1;
      count <= next_count;
      out_valid <= next_valid;
    end
  end
endmodule
`default_nettype wire

// *** rtl/pvc_top.sv ***
`default_nettype none
module pvc_top #(
  parameter int N_CH = 2,
  parameter int ADC_SPAN = 10000
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cfg_write,
  input wire pvc_pkg::pvc_cfg_s cfg_in,
  input wire logic [1:0] avg_enable,
  input wire logic has_ctrl_out2,
  input wire logic four_aux,
  input wire logic heater_fault_fitted,
  input wire logic asg_write,
  input wire logic [2:0] asg_index,
  input wire pvc_pkg::pvc_func_e asg_func,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_ch,
  input wire logic signed [15:0] in_sample,
  output logic out_valid,
  input wire logic out_ready,
  output pvc_pkg::pvc_pv_s out_pv,
  input wire logic signed [15:0] set_point,
  input wire logic heat_request,
  input wire logic cool_request,
  input wire logic [3:0] alarm,
  input wire logic heater_fault_alarm,
  input wire logic program_end,
  input wire logic invert_action_event,
  output logic [5:0] out_drive,
  output pvc_pkg::pvc_cfg_s cfg_active
);
  // arrays and the enable port serve at most two channels
  if (N_CH < 1 || N_CH > 2 || ADC_SPAN < 1) begin : g_bad_params
    $error("pvc_top: unsupported parameters");
  end


  ////////////////////////////////////////////////////////////////////////
  // configuration register with clamping
  pvc_pkg::pvc_cfg_s cfg, next_cfg;
  logic cfg_avg_changed;

  always_comb begin
    next_cfg = cfg;
    if (cfg_write) begin
      next_cfg = cfg_in;
      if (cfg_in.slope < pvc_pkg::SLOPE_MIN) next_cfg.slope = pvc_pkg::SLOPE_MIN; // R3
      if (cfg_in.slope > pvc_pkg::SLOPE_MAX) next_cfg.slope = pvc_pkg::SLOPE_MAX; // R3
      if (cfg_in.offset < pvc_pkg::OFS_MIN) next_cfg.offset = pvc_pkg::OFS_MIN; // R2
      if (cfg_in.offset > pvc_pkg::OFS_MAX) next_cfg.offset = pvc_pkg::OFS_MAX; // R2
      if (cfg_in.avg_code > pvc_pkg::AVG_MAX_CODE) next_cfg.avg_code = pvc_pkg::AVG_OFF; // R4
    end
  end
  assign cfg_avg_changed = (next_cfg.avg_code != cfg.avg_code);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg.slope <= pvc_pkg::SLOPE_UNITY; // R3
      cfg.offset <= pvc_pkg::OFS_RESET; // R2
      cfg.avg_code <= pvc_pkg::AVG_OFF; // R4
      cfg.scale_lo <= pvc_pkg::SCALE_LO_RESET; // R7
      cfg.scale_hi <= pvc_pkg::SCALE_HI_RESET;
      cfg.decimal_place_setting <= pvc_pkg::DEC_RESET; // R8
      cfg.dead_band <= pvc_pkg::DB_RESET; // R20
      cfg.tune <= pvc_pkg::TUNE_RESET; // R22
      cfg.heat_cool <= 1'b0;
      cfg.direct <= 1'b0;
      cfg.prog_on <= 1'b0;
      cfg.analog <= 1'b0;
    end else begin
      cfg <= next_cfg;
    end
  end
  assign cfg_active = cfg;

  ////////////////////////////////////////////////////////////////////////
  // sample pipeline: accept, correct and scale, average
  pvc_pkg::pvc_state_e state, next_state;
  logic signed [15:0] raw, next_raw, corr, next_corr;
  logic ch, next_ch;
  logic [4:0] wptr [0:1];
  logic [4:0] next_wptr [0:1];
  logic [5:0] fill [0:1];
  logic [5:0] next_fill [0:1];
  logic signed [21:0] sum [0:1];
  logic signed [21:0] next_sum [0:1];
  logic signed [31:0] prod;
  logic signed [31:0] shifted;
  logic signed [47:0] span_prod;
  logic signed [31:0] scaled;
  logic signed [15:0] old_val, mean;
  logic [15:0] rd_word;
  logic [5:0] navg;
  logic [2:0] shamt;
  logic avg_on, buf_in_ready, push;
  logic signed [21:0] sum_upd;

  // corrected value and linear scaling of the analog span
  always_comb begin
    prod = raw * $signed({2'b00, cfg.slope}); // R1
    shifted = prod / 32'sd1000 + 32'(cfg.offset); // R1
    span_prod = 48'(shifted) * 48'(32'(cfg.scale_hi) - 32'(cfg.scale_lo)); // R7
    scaled = cfg.analog ? 32'(cfg.scale_lo) + 32'(span_prod / 48'(ADC_SPAN)) : shifted; // R7
    if (scaled > 32'sd32767) next_corr = 16'sh7fff;
    else if (scaled < -32'sd32768) next_corr = 16'sh8000;
    else next_corr = scaled[15:0];
  end

  // averaging length from the code: 2 to the code
  assign shamt = cfg.avg_code;
  assign navg = 6'(1) << shamt;
  assign avg_on = (cfg.avg_code != pvc_pkg::AVG_OFF) && avg_enable[ch]; // R4 R5
  assign old_val = (fill[ch] >= navg) ? $signed(rd_word) : 16'sh0000; // R6
  assign sum_upd = sum[ch] - 22'(old_val) + 22'(corr); // R6
  assign mean = avg_on ? 16'(sum_upd >>> shamt) : corr; // R6
  assign push = (state == pvc_pkg::ST_AVG) && buf_in_ready;

  always_comb begin
    next_state = state;
    next_raw = raw;
    next_ch = ch;
    for (int i = 0; i < 2; i++) begin
      next_wptr[i] = wptr[i];
      next_fill[i] = fill[i];
      next_sum[i] = sum[i];
    end
    case (state)
      pvc_pkg::ST_IDLE: begin
        if (in_valid) begin
          next_raw = in_sample;
          next_ch = (N_CH > 1) ? in_ch : 1'b0;
          next_state = pvc_pkg::ST_CORR;
        end
      end
      pvc_pkg::ST_CORR: next_state = pvc_pkg::ST_AVG;
      pvc_pkg::ST_AVG: begin
        if (push) begin
          next_wptr[ch] = wptr[ch] + 5'h01;
          next_fill[ch] = (fill[ch] == 6'h20) ? fill[ch] : fill[ch] + 6'h01;
          next_sum[ch] = sum_upd;
          next_state = pvc_pkg::ST_IDLE;
        end
      end
      default: next_state = pvc_pkg::ST_IDLE;
    endcase
    // a new length restarts the window so the mean never mixes lengths
    if (cfg_avg_changed) begin
      for (int i = 0; i < 2; i++) begin
        next_fill[i] = 6'h00; // R6
        next_sum[i] = 22'sh0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= pvc_pkg::ST_IDLE;
      raw <= 16'sh0000;
      corr <= 16'sh0000;
      ch <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        wptr[i] <= 5'h00;
        fill[i] <= 6'h00;
        sum[i] <= 22'sh0;
      end
    end else begin
      state <= next_state;
      raw <= next_raw;
      corr <= (state == pvc_pkg::ST_CORR) ? next_corr : corr;
      ch <= next_ch;
      for (int i = 0; i < 2; i++) begin
        wptr[i] <= next_wptr[i];
        fill[i] <= next_fill[i];
        sum[i] <= next_sum[i];
      end
    end
  end
  assign in_ready = state[0]; // idle bit of the one-hot code, straight from its flop

  // history read issued in the correct cycle, used in the average cycle
  pvc_hist_mem #(.AW(6), .DW(16)) u_hist (
    .ref_clk(ref_clk),
    .wr_en(push),
    .wr_addr({ch, wptr[ch]}),
    .wr_data(corr),
    .rd_addr({ch, wptr[ch] - 5'(navg)}),
    .rd_data(rd_word)
  );

  pvc_skid_buf #(.W($bits(pvc_pkg::pvc_pv_s))) u_buf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(state == pvc_pkg::ST_AVG),
    .in_ready(buf_in_ready),
    .in_data({ch, mean, cfg.decimal_place_setting}), // R8
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_pv)
  );

  ////////////////////////////////////////////////////////////////////////
  // output assignment table: ctrl1, ctrl2, aux1..aux4
  pvc_pkg::pvc_func_e asg [0:5];
  pvc_pkg::pvc_func_e next_asg [0:5];
  pvc_pkg::pvc_func_e dflt [0:5];
  logic prev_hc, prev_prog, prev_hfit;

  always_comb begin
    dflt[0] = pvc_pkg::FN_HEAT; // R10
    dflt[1] = (cfg.heat_cool && has_ctrl_out2) ? pvc_pkg::FN_COOL : pvc_pkg::FN_NONE; // R9 R12
    dflt[2] = cfg.prog_on ? pvc_pkg::FN_PEND : // R14
              (heater_fault_fitted ? pvc_pkg::FN_HEATER : pvc_pkg::FN_ALM1); // R11
    dflt[3] = (cfg.heat_cool && !has_ctrl_out2 && !four_aux) ? pvc_pkg::FN_COOL : pvc_pkg::FN_ALM2; // R12
    dflt[4] = pvc_pkg::FN_ALM3;
    dflt[5] = (cfg.heat_cool && !has_ctrl_out2 && four_aux) ? pvc_pkg::FN_COOL : pvc_pkg::FN_ALM4; // R13
    for (int i = 0; i < 6; i++) begin
      next_asg[i] = asg[i];
      if (asg_write && asg_index == 3'(i)) next_asg[i] = asg_func;
      // a mode change rewrites every assignment
      if (cfg.heat_cool != prev_hc || cfg.prog_on != prev_prog || heater_fault_fitted != prev_hfit) begin
        next_asg[i] = dflt[i]; // R12
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      asg[0] <= pvc_pkg::FN_HEAT; // R10
      asg[1] <= pvc_pkg::FN_NONE;
      asg[2] <= pvc_pkg::FN_ALM1;
      asg[3] <= pvc_pkg::FN_ALM2;
      asg[4] <= pvc_pkg::FN_ALM3;
      asg[5] <= pvc_pkg::FN_ALM4;
      prev_hc <= 1'b0;
      prev_prog <= 1'b0;
      prev_hfit <= 1'b0;
    end else begin
      for (int i = 0; i < 6; i++) asg[i] <= next_asg[i];
      prev_hc <= cfg.heat_cool;
      prev_prog <= cfg.prog_on;
      prev_hfit <= heater_fault_fitted;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event synchroniser, dead band and direction
  logic evt_s1, evt_s2, eff_direct;
  logic signed [15:0] pv_now;
  logic signed [16:0] band_lo, band_hi;
  logic below, above, raw_heat, raw_cool, heat_drive, cool_drive;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      evt_s1 <= 1'b0;
      evt_s2 <= 1'b0;
      pv_now <= 16'sh0000;
    end else begin
      evt_s1 <= invert_action_event;
      evt_s2 <= evt_s1;
      pv_now <= (push && ch == 1'b0) ? mean : pv_now;
    end
  end

  // band spans exactly dead_band, centred on the set point
  always_comb begin
    band_lo = 17'(set_point) - 17'(cfg.dead_band >>> 1); // R17
    band_hi = band_lo + 17'(cfg.dead_band); // R17
    below = 17'(pv_now) < band_hi && 17'(pv_now) <= band_lo; // R17
    above = 17'(pv_now) > band_hi || (cfg.dead_band < 0 && 17'(pv_now) >= band_hi); // R18
    if (cfg.dead_band < 0) below = 17'(pv_now) <= band_lo; // R18
    eff_direct = cfg.direct ^ evt_s2; // R16
    raw_heat = heat_request && (!cfg.heat_cool || below);
    raw_cool = cfg.heat_cool && cool_request && above; // R9
    // no bumpless tracking: manual/auto handover may step the output
    heat_drive = (eff_direct && cfg.heat_cool) ? raw_cool : raw_heat; // R15 R19
    cool_drive = (eff_direct && cfg.heat_cool) ? raw_heat : raw_cool; // R15
  end

  // route functions to the six outputs, registered
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_out
      logic sel;
      always_comb begin
        case (asg[g])
          pvc_pkg::FN_HEAT: sel = heat_drive;
          pvc_pkg::FN_COOL: sel = cool_drive;
          pvc_pkg::FN_ALM1: sel = alarm[0];
          pvc_pkg::FN_ALM2: sel = alarm[1];
          pvc_pkg::FN_ALM3: sel = alarm[2];
          pvc_pkg::FN_ALM4: sel = alarm[3];
          pvc_pkg::FN_HEATER: sel = heater_fault_alarm;
          pvc_pkg::FN_PEND: sel = program_end;
          default: sel = 1'b0;
        endcase
      end
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) out_drive[g] <= 1'b0;
        else out_drive[g] <= sel;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_SLOPE_RANGE: assert property (@(posedge ref_clk) disable iff (!nrst) // R3
    cfg.slope >= pvc_pkg::SLOPE_MIN && cfg.slope <= pvc_pkg::SLOPE_MAX) else $error("slope out of range");
  AST_OFFSET_RANGE: assert property (@(posedge ref_clk) disable iff (!nrst) // R2
    cfg_write |=> cfg.offset >= pvc_pkg::OFS_MIN && cfg.offset <= pvc_pkg::OFS_MAX) else $error("offset out of range");
  AST_PASS_THROUGH: assert property (@(posedge ref_clk) disable iff (!nrst) // R4
    push && !avg_on |=> out_valid && (out_pv.value == $past(corr) || $past(out_valid)))
    else $error("unaveraged value not passed");
  AST_CTRL1_HEAT: assert property (@(posedge ref_clk) disable iff (!nrst) // R10
    $rose(nrst) |-> asg[0] == pvc_pkg::FN_HEAT && asg[1] == pvc_pkg::FN_NONE) else $error("reset assignment wrong");
  AST_MODE_REINIT: assert property (@(posedge ref_clk) disable iff (!nrst) // R12
    $changed(cfg.heat_cool) && !asg_write |=> asg[1] == $past(dflt[1]) && asg[3] == $past(dflt[3]))
    else $error("assignments not reinitialised");
  AST_AUX4_COOL: assert property (@(posedge ref_clk) disable iff (!nrst) // R13
    $rose(cfg.heat_cool) && four_aux && !has_ctrl_out2 && !asg_write |=> asg[5] == pvc_pkg::FN_COOL
    && asg[3] == pvc_pkg::FN_ALM2) else $error("aux4 not cooling");
  AST_PROG_END: assert property (@(posedge ref_clk) disable iff (!nrst) // R14
    $rose(cfg.prog_on) && !asg_write |=> asg[2] == pvc_pkg::FN_PEND) else $error("aux1 not program end");
  AST_INVERT_EVENT: assert property (@(posedge ref_clk) disable iff (!nrst) // R16
    $rose(invert_action_event) ##2 !$fell(evt_s2) |-> eff_direct == !cfg.direct) else $error("direction not inverted");
  AST_OVERLAP: assert property (@(posedge ref_clk) disable iff (!nrst) // R18
    cfg.dead_band < 0 && pv_now == set_point |-> below && above) else $error("no overlap at set point");
  AST_OUT_LATENCY: assert property (@(posedge ref_clk) disable iff (!nrst) // R9
    asg[1] == pvc_pkg::FN_COOL && $stable(asg[1]) |=> out_drive[1] == $past(cool_drive)) else $error("cooling not routed");
endmodule
`default_nettype wire

// *** tb/pvc_front_model.sv ***
`default_nettype none
// sensor front end feeding samples and the sink taking conditioned words
module pvc_front_model (
  input wire logic ref_clk,
  input wire logic in_ready,
  input wire logic stall,
  input wire logic hold,
  output logic in_valid,
  output logic in_ch,
  output logic signed [15:0] in_sample,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 25482;

  // idle bus at time zero
  initial begin
    in_valid = 1'b0;
    in_ch = 1'b0;
    in_sample = 16'h5a5a;
    out_ready = 1'b1;
  end

  // sink ready: held off on demand, or dropped at random while stalling
  always @(negedge ref_clk) begin
    out_ready <= !hold && (!stall || ($random(seed) & 1) == 0);
  end

  // one sample held until taken; afterwards the bus shows the inverse
  task automatic send(input logic c, input logic signed [15:0] v);
    @(negedge ref_clk);
    in_ch = c;
    in_sample = v;
    in_valid = 1'b1;
    while (in_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    @(negedge ref_clk);
    in_valid = 1'b0;
    in_sample = ~v;
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, nrst = 1'b0, cfg_write = 1'b0, in_valid, in_ready, in_ch, out_valid, out_ready;
  logic has_ctrl_out2 = 1'b0, four_aux = 1'b0, heater_fault_fitted = 1'b0, stall = 1'b0, hold = 1'b0;
  logic heat_request = 1'b0, cool_request = 1'b0, heater_fault_alarm = 1'b0, program_end = 1'b0;
  logic invert_action_event = 1'b0, asg_write = 1'b0;
  logic [2:0] asg_index = 3'h0;
  pvc_pkg::pvc_func_e asg_func = pvc_pkg::FN_NONE;
  logic [1:0] avg_enable = 2'h0;
  logic [3:0] alarm = 4'h0;
  logic [5:0] out_drive;
  logic signed [15:0] in_sample, set_point = 16'sh0000;
  pvc_pkg::pvc_cfg_s cfg_in, cfg_active, cfg;
  pvc_pkg::pvc_pv_s out_pv;
  pvc_pkg::pvc_pv_s exp_q[$];
  int fail_count = 0, n_compared = 0, seed = 25482, v, s;
  int win[$];
  int dbt[4] = '{100, 100, 100, -100};
  int pvt[4] = '{50, 51, -50, 0};
  logic [5:0] dvt[4] = '{6'h04, 6'h0c, 6'h05, 6'h0d};

  pvc_top #(.N_CH(2), .ADC_SPAN(10000)) u_pvc_top (.ref_clk(ref_clk), .nrst(nrst), .cfg_write(cfg_write),
    .cfg_in(cfg_in), .avg_enable(avg_enable), .has_ctrl_out2(has_ctrl_out2), .four_aux(four_aux),
    .heater_fault_fitted(heater_fault_fitted), .asg_write(asg_write), .asg_index(asg_index), .asg_func(asg_func),
    .in_valid(in_valid), .in_ready(in_ready), .in_ch(in_ch), .in_sample(in_sample), .out_valid(out_valid),
    .out_ready(out_ready), .out_pv(out_pv), .set_point(set_point), .heat_request(heat_request),
    .cool_request(cool_request), .alarm(alarm), .heater_fault_alarm(heater_fault_alarm),
    .program_end(program_end), .invert_action_event(invert_action_event), .out_drive(out_drive),
    .cfg_active(cfg_active));

  pvc_front_model u_pvc_front_model (.ref_clk(ref_clk), .in_ready(in_ready), .stall(stall), .hold(hold),
    .in_valid(in_valid), .in_ch(in_ch), .in_sample(in_sample), .out_ready(out_ready));

  ////////////////////////////////////////////////////////////////////////////////
  // clock
  always #20 ref_clk = ~ref_clk;

  // configuration equal to the reset state
  function automatic pvc_pkg::pvc_cfg_s base();
    pvc_pkg::pvc_cfg_s c;
    c = '0;
    c.slope = 14'h03e8;
    c.scale_hi = 16'sh0064;
    return c;
  endfunction

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic drain();
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge ref_clk);
  endtask

  task automatic wcfg();
    drain();
    @(negedge ref_clk);
    cfg_in = cfg;
    cfg_write = 1'b1;
    @(negedge ref_clk);
    cfg_write = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic feed(input logic c, input logic signed [15:0] x, input logic signed [15:0] e, input logic [1:0] d);
    exp_q.push_back({c, e, d});
    u_pvc_front_model.send(c, x);
  endtask

  // output drive settles through register and event synchroniser
  task automatic dchk(input logic [5:0] e);
    drain();
    repeat (6) @(negedge ref_clk);
    chk(out_drive, e);
  endtask

  task automatic wrap_up();
    if (exp_q.size() != 0) fail_count++;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // each delivered word against the oldest note
  always @(posedge ref_clk) begin
    if (nrst && out_valid === 1'b1 && out_ready === 1'b1) begin
      chk(out_pv, exp_q.size() > 0 ? exp_q.pop_front() : {128{1'bx}});
    end
  end

  // watchdog
  initial begin
    #(40 * 40000);
    fail_count++;
    wrap_up();
  end

  // stimulus
  initial begin
    cfg = base();
    cfg_in = cfg;
    repeat (8) @(negedge ref_clk);
    chk(cfg_active, base());
    chk({in_ready, out_valid, out_drive}, 8'h80);
    nrst = 1'b1;
    $display("test reset done");
    cfg.slope = 14'h0348;
    cfg.offset = 16'sh0082;
    wcfg();
    stall = 1'b1;
    feed(0, 500, 550, 2'h0);
    feed(0, 1000, 970, 2'h0);
    for (int k = 0; k < 6; k++) begin
      v = $random(seed) % 1000;
      feed(k[0], v, v * 840 / 1000 + 130, 2'h0);
    end
    stall = 1'b0;
    cfg.slope = 14'h0000;
    cfg.offset = -16'sd3000;
    cfg.avg_code = 3'h7;
    wcfg();
    chk({cfg_active.slope, cfg_active.offset, cfg_active.avg_code}, {14'h0001, -16'sd1999, 3'h0});
    cfg.slope = 14'h3fff;
    cfg.offset = 16'sh2710;
    wcfg();
    chk({cfg_active.slope, cfg_active.offset}, {14'h270f, 16'sh270f});
    for (int k = 0; k < 4; k++) begin
      cfg.tune = pvc_pkg::pvc_tune_e'(k);
      wcfg();
      chk(cfg_active.tune, k[1:0]);
    end
    $display("test correction done");
    // sink held off: the pipeline fills and refuses, no word lost
    cfg = base();
    wcfg();
    hold = 1'b1;
    fork
      for (int k = 0; k < 4; k++) feed(0, 16'(k * 7), 16'(k * 7), 2'h0);
    join_none
    repeat (30) @(negedge ref_clk);
    chk(in_ready, 1'b0);
    hold = 1'b0;
    wait fork;
    $display("test buffer done");
    avg_enable = 2'b01;
    for (int c = 1; c <= 5; c++) begin
      cfg.avg_code = 3'(c);
      wcfg();
      win.delete();
      for (int k = 0; k < (1 << c) + 2; k++) begin
        v = $random(seed) & 32'h3ff;
        win.push_back(v);
        if (win.size() > (1 << c)) void'(win.pop_front());
        s = win.sum();
        feed(0, v, s >> c, 2'h0);
      end
      feed(1, 16'sh0123, 16'sh0123, 2'h0);
    end
    avg_enable = 2'b00;
    $display("test averaging done");
    cfg = base();
    cfg.analog = 1'b1;
    cfg.scale_lo = 16'sh0064;
    cfg.scale_hi = 16'sh03b6;
    cfg.decimal_place_setting = 2'h1;
    wcfg();
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 5000 : ($random(seed) & 32'h1fff);
      feed(0, v, 100 + v * 850 / 10000, 2'h1);
    end
    $display("test scaling done");
    cfg = base();
    wcfg();
    heat_request = 1'b1;
    cool_request = 1'b1;
    alarm = 4'b1010;
    feed(0, -100, -100, 2'h0);
    dchk(6'h29);
    heater_fault_fitted = 1'b1;
    heater_fault_alarm = 1'b1;
    dchk(6'h2d);
    heater_fault_alarm = 1'b0;
    program_end = 1'b1;
    cfg.prog_on = 1'b1;
    wcfg();
    dchk(6'h2d);
    cfg.prog_on = 1'b0;
    wcfg();
    heater_fault_fitted = 1'b0;
    program_end = 1'b0;
    alarm = 4'b0001;
    four_aux = 1'b1;
    cfg.tune = pvc_pkg::TUNE_AIR;
    cfg.dead_band = 16'sh0000;
    cfg.heat_cool = 1'b1;
    wcfg();
    feed(0, 500, 500, 2'h0);
    dchk(6'h24);
    cfg.direct = 1'b1;
    wcfg();
    dchk(6'h05);
    invert_action_event = 1'b1;
    dchk(6'h24);
    invert_action_event = 1'b0;
    dchk(6'h05);
    // user override of aux3; the next mode change must wipe it
    @(negedge ref_clk);
    asg_index = 3'h4;
    asg_func = pvc_pkg::FN_ALM1;
    asg_write = 1'b1;
    @(negedge ref_clk);
    asg_write = 1'b0;
    dchk(6'h15);
    cfg.direct = 1'b0;
    cfg.heat_cool = 1'b0;
    wcfg();
    has_ctrl_out2 = 1'b1;
    cfg.heat_cool = 1'b1;
    wcfg();
    dchk(6'h06);
    cfg.heat_cool = 1'b0;
    wcfg();
    has_ctrl_out2 = 1'b0;
    four_aux = 1'b0;
    cfg.heat_cool = 1'b1;
    wcfg();
    dchk(6'h0c);
    $display("test assignment done");
    for (int k = 0; k < 4; k++) begin
      cfg.dead_band = 16'(dbt[k]);
      wcfg();
      feed(0, 16'(pvt[k]), 16'(pvt[k]), 2'h0);
      dchk(dvt[k]);
    end
    $display("test dead band done");
    drain();
    wrap_up();
  end
endmodule
`default_nettype wire
